// >>> src/csp_pkg.sv
package csp_pkg;

	// Timebase of the block clock.
	localparam int CLK_HZ   = 125_000_000;

	// Serial clock rates selectable by the rate code.
	localparam int RATE0_HZ = 4_000_000;
	localparam int RATE1_HZ = 2_000_000;
	localparam int RATE2_HZ = 1_000_000;
	localparam int RATE3_HZ = 500_000;
	localparam int RATE4_HZ = 250_000;

	// Half serial periods in block clocks, rounded down.
	localparam logic [7:0] HALF0 = 8'(CLK_HZ / (2 * RATE0_HZ));
	localparam logic [7:0] HALF1 = 8'(CLK_HZ / (2 * RATE1_HZ));
	localparam logic [7:0] HALF2 = 8'(CLK_HZ / (2 * RATE2_HZ));
	localparam logic [7:0] HALF3 = 8'(CLK_HZ / (2 * RATE3_HZ));
	localparam logic [7:0] HALF4 = 8'(CLK_HZ / (2 * RATE4_HZ));

	// Parameter limits and codes.
	localparam logic [7:0] MODE_MAX = 8'h03;
	localparam logic [7:0] RATE_MAX = 8'h04;
	localparam logic [7:0] CS_SEL_A = 8'h04;
	localparam logic [7:0] CS_SEL_B = 8'h05;
	localparam logic [7:0] LEN_MAX  = 8'h08;

	// Values after reset.
	localparam logic [7:0] HALF_RST = 8'h0f;
	localparam logic       CPOL_RST = 1'h0;
	localparam logic       CPHA_RST = 1'h0;

	// Response word: ok flag, byte count, data.
	localparam int RESP_W = 69;
	localparam int RESP_DEPTH = 2;

	typedef enum logic [2:0] {
		OP_M_EN    = 3'h0,
		OP_M_DIS   = 3'h1,
		OP_XFER    = 3'h2,
		OP_S_EN    = 3'h3,
		OP_S_DIS   = 3'h4,
		OP_S_READ  = 3'h5,
		OP_S_WRITE = 3'h6
	} csp_op_t;

	typedef enum logic [1:0] {
		ROLE_OFF    = 2'h0,
		ROLE_MASTER = 2'h1,
		ROLE_SLAVE  = 2'h2
	} csp_role_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_MRUN  = 3'b010,
		ST_SREAD = 3'b100
	} csp_state_t;

endpackage : csp_pkg

// >>> src/csp_stream_if.sv
`timescale 1ns/1ns
interface csp_stream_if #(parameter int W = 8) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] word;
	modport src (output valid, output word, input ready);
	modport snk (input valid, input word, output ready);
endinterface : csp_stream_if

// >>> src/csp_buffer.sv
`timescale 1ns/1ns
module csp_buffer
	import csp_pkg::*;
	#(
	parameter int W     = 8,
	parameter int DEPTH = 2
	) (
	input  wire logic         mclk,
	input  wire logic         rst,
	csp_stream_if.snk         in_s,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_word
	);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem      [DEPTH];
	logic [W-1:0]  next_mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr;
	logic [AW-1:0] rd_ptr, next_rd_ptr;
	logic [AW:0]   count,  next_count;
	logic          push, pop;

	// Full and empty follow the entry count exactly.
	assign in_s.ready = (count != (AW+1)'(DEPTH));
	assign out_valid  = (count != '0);
	assign out_word   = mem[rd_ptr];
	assign push       = in_s.valid & in_s.ready;
	assign pop        = out_valid & out_ready;

	// Next pointers, count and storage.
	always_comb begin
		next_mem    = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_mem[wr_ptr] = in_s.word;
			next_wr_ptr      = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// Registers of the buffer.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			mem    <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

endmodule : csp_buffer

// >>> src/csp_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Mode code 0..3 sets CPOL/CPHA as 00, 01, 10, 11.
// - Rate code 0..4 selects 4M, 2M, 1M, 500k, 250k serial clock.
// - Master chip select drives pin A for code 04, pin B for 05.
// - Master enable takes mode, rate, select and makes the block master.
// - Master disable carries a select code; valid turns off, invalid errors.
// - Master transfer shifts up to eight bytes and returns the bytes received.
// - Slave enable takes mode and rate and makes the block slave.
// - In slave role pin B is the chip select input from the master.
// - Slave read collects the given byte count from the master and returns it.
// - Slave write loads up to eight bytes for the master to clock out.
// - Each command answers success, or error on a bad parameter or, for transfer, slave read and slave write, the wrong role.
// - Slave disable leaves slave role and answers success.
module csp_top
	import csp_pkg::*;
	(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire csp_op_t     cmd_op,
	input  wire logic [7:0]  cmd_mode,
	input  wire logic [7:0]  cmd_rate,
	input  wire logic [7:0]  cmd_cs_sel,
	input  wire logic [7:0]  cmd_len,
	input  wire logic [63:0] cmd_data,
	output logic             resp_valid,
	input  wire logic        resp_ready,
	output logic             resp_ok,
	output logic [3:0]       resp_len,
	output logic [63:0]      resp_data,
	output logic             role_master,
	output logic             role_slave,
	input  wire logic        sclk_i,
	output logic             sclk_o,
	output logic             sclk_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	output logic             cs_a_n_o,
	output logic             cs_a_oe,
	input  wire logic        cs_b_n_i,
	output logic             cs_b_n_o,
	output logic             cs_b_oe
	);

	csp_stream_if #(.W(RESP_W)) rs ();

	csp_role_t   role,     next_role;
	csp_state_t  state,    next_state;
	logic        cpol,     next_cpol;
	logic        cpha,     next_cpha;
	logic [7:0]  half_lim, next_half_lim;
	logic        sel_b,    next_sel_b;
	logic [7:0]  div_cnt,  next_div_cnt;
	logic [7:0]  edge_cnt, next_edge_cnt;
	logic [6:0]  bit_cnt,  next_bit_cnt;
	logic [6:0]  bit_lim,  next_bit_lim;
	logic        sclk_lvl, next_sclk_lvl;
	logic        first,    next_first;
	logic        csa_n,    next_csa_n;
	logic        csb_n,    next_csb_n;
	logic [63:0] tx,       next_tx;
	logic [63:0] rx,       next_rx;
	logic        push,     next_push;
	logic        rsp_ok,   next_rsp_ok;
	logic [3:0]  rsp_len,  next_rsp_len;
	logic [63:0] rsp_data, next_rsp_data;
	logic        sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, mosi_s1, mosi_s2, miso_s1, miso_s2;
	logic        accept, mode_ok, rate_ok, sel_ok, len_ok, tick, m_edge, m_end;
	logic        lead, trail, sample, shift, rx_in;
	logic [7:0]  rate_half;

	// Checks of the command parameters.
	assign mode_ok = (cmd_mode <= MODE_MAX);
	assign rate_ok = (cmd_rate <= RATE_MAX);
	assign sel_ok  = (cmd_cs_sel == CS_SEL_A) || (cmd_cs_sel == CS_SEL_B);
	assign len_ok  = (cmd_len != 8'h00) && (cmd_len <= LEN_MAX);
	assign accept  = cmd_valid & cmd_ready;

	// Commands are taken only when idle and a response slot is free.
	assign cmd_ready = (state == ST_IDLE) & rs.ready & ~push;

	// Rate code to half serial period.
	always_comb begin
		case (cmd_rate[2:0])
			3'h0:    rate_half = HALF0;
			3'h1:    rate_half = HALF1;
			3'h2:    rate_half = HALF2;
			3'h3:    rate_half = HALF3;
			default: rate_half = HALF4;
		endcase
	end

	// Serial clock edges: generated in master role, detected in slave role.
	assign tick   = (state == ST_MRUN) && (div_cnt == half_lim - 8'h01);
	assign m_edge = tick && (edge_cnt < {bit_lim, 1'b0});
	assign m_end  = tick && (edge_cnt == {bit_lim, 1'b0});
	assign lead   = (m_edge & ~edge_cnt[0]) |
		((role == ROLE_SLAVE) & ~cs_s2 & (sclk_s2 != sclk_s3) & (sclk_s2 != cpol));
	assign trail  = (m_edge & edge_cnt[0]) |
		((role == ROLE_SLAVE) & ~cs_s2 & (sclk_s2 != sclk_s3) & (sclk_s2 == cpol));
	assign sample = cpha ? trail : lead;
	assign shift  = cpha ? (lead & ~first) : trail;
	assign rx_in  = (role == ROLE_MASTER) ? miso_s2 : mosi_s2;

	// Command decode, shifting and response build.
	always_comb begin
		next_role     = role;
		next_state    = state;
		next_cpol     = cpol;
		next_cpha     = cpha;
		next_half_lim = half_lim;
		next_sel_b    = sel_b;
		next_div_cnt  = div_cnt;
		next_edge_cnt = edge_cnt;
		next_bit_cnt  = bit_cnt;
		next_bit_lim  = bit_lim;
		next_sclk_lvl = sclk_lvl;
		next_first    = first;
		next_csa_n    = csa_n;
		next_csb_n    = csb_n;
		next_tx       = tx;
		next_rx       = rx;
		next_push     = 1'b0;
		next_rsp_ok   = rsp_ok;
		next_rsp_len  = rsp_len;
		next_rsp_data = rsp_data;
		if (sample) begin
			next_rx      = {rx[62:0], rx_in};
			next_bit_cnt = bit_cnt + 7'h01;
		end
		if (shift) begin
			next_tx = {tx[62:0], 1'b0};
		end
		if (lead) begin
			next_first = 1'b0;
		end
		if ((role == ROLE_SLAVE) && cs_s2) begin
			next_first = 1'b1;
		end
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_push     = 1'b1;
					next_rsp_ok   = 1'b1;
					next_rsp_len  = 4'h0;
					next_rsp_data = 64'h0;
					case (cmd_op)
						OP_M_EN: begin
							if (mode_ok && rate_ok && sel_ok) begin
								next_role     = ROLE_MASTER;
								next_cpol     = cmd_mode[1];
								next_cpha     = cmd_mode[0];
								next_sclk_lvl = cmd_mode[1];
								next_half_lim = rate_half;
								next_sel_b    = (cmd_cs_sel == CS_SEL_B);
							end else begin
								next_rsp_ok = 1'b0;
							end
						end
						OP_M_DIS: begin
							if (sel_ok) begin
								next_role = ROLE_OFF;
							end else begin
								next_rsp_ok = 1'b0;
							end
						end
						OP_XFER: begin
							if ((role == ROLE_MASTER) && sel_ok && len_ok) begin
								next_push     = 1'b0;
								next_state    = ST_MRUN;
								next_sel_b    = (cmd_cs_sel == CS_SEL_B);
								next_csa_n    = (cmd_cs_sel == CS_SEL_B);
								next_csb_n    = (cmd_cs_sel == CS_SEL_A);
								next_tx       = cmd_data;
								next_rx       = 64'h0;
								next_bit_cnt  = 7'h00;
								next_bit_lim  = {cmd_len[3:0], 3'h0};
								next_rsp_len  = cmd_len[3:0];
								next_div_cnt  = 8'h00;
								next_edge_cnt = 8'h00;
								next_first    = 1'b1;
							end else begin
								next_rsp_ok = 1'b0;
							end
						end
						OP_S_EN: begin
							if (mode_ok && rate_ok) begin
								next_role     = ROLE_SLAVE;
								next_cpol     = cmd_mode[1];
								next_cpha     = cmd_mode[0];
								next_sclk_lvl = cmd_mode[1];
								next_half_lim = rate_half;
							end else begin
								next_rsp_ok = 1'b0;
							end
						end
						OP_S_DIS: begin
							if (role == ROLE_SLAVE) begin
								next_role = ROLE_OFF;
							end
						end
						OP_S_READ: begin
							if ((role == ROLE_SLAVE) && len_ok) begin
								next_push    = 1'b0;
								next_state   = ST_SREAD;
								next_rx      = 64'h0;
								next_bit_cnt = 7'h00;
								next_bit_lim = {cmd_len[3:0], 3'h0};
								next_rsp_len = cmd_len[3:0];
							end else begin
								next_rsp_ok = 1'b0;
							end
						end
						OP_S_WRITE: begin
							if ((role == ROLE_SLAVE) && len_ok) begin
								next_tx = cmd_data;
							end else begin
								next_rsp_ok = 1'b0;
							end
						end
						default: begin
							next_rsp_ok = 1'b0;
						end
					endcase
				end
			end
			ST_MRUN: begin
				next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
				if (tick) begin
					next_edge_cnt = edge_cnt + 8'h01;
				end
				if (m_edge) begin
					next_sclk_lvl = ~sclk_lvl;
				end
				if (m_end) begin
					next_state    = ST_IDLE;
					next_csa_n    = 1'b1;
					next_csb_n    = 1'b1;
					next_sclk_lvl = cpol;
					next_push     = 1'b1;
					next_rsp_data = rx;
				end
			end
			ST_SREAD: begin
				if (bit_cnt == bit_lim) begin
					next_state    = ST_IDLE;
					next_push     = 1'b1;
					next_rsp_data = rx;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State registers and input synchronisers.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			role     <= ROLE_OFF;
			state    <= ST_IDLE;
			cpol     <= CPOL_RST;
			cpha     <= CPHA_RST;
			half_lim <= HALF_RST;
			sel_b    <= 1'b0;
			div_cnt  <= 8'h00;
			edge_cnt <= 8'h00;
			bit_cnt  <= 7'h00;
			bit_lim  <= 7'h00;
			sclk_lvl <= CPOL_RST;
			first    <= 1'b1;
			csa_n    <= 1'b1;
			csb_n    <= 1'b1;
			tx       <= 64'h0;
			rx       <= 64'h0;
			push     <= 1'b0;
			rsp_ok   <= 1'b0;
			rsp_len  <= 4'h0;
			rsp_data <= 64'h0;
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{cs_s1, cs_s2}              <= 2'h3;
			{mosi_s1, mosi_s2}          <= 2'h0;
			{miso_s1, miso_s2}          <= 2'h0;
		end else begin
			role     <= next_role;
			state    <= next_state;
			cpol     <= next_cpol;
			cpha     <= next_cpha;
			half_lim <= next_half_lim;
			sel_b    <= next_sel_b;
			div_cnt  <= next_div_cnt;
			edge_cnt <= next_edge_cnt;
			bit_cnt  <= next_bit_cnt;
			bit_lim  <= next_bit_lim;
			sclk_lvl <= next_sclk_lvl;
			first    <= next_first;
			csa_n    <= next_csa_n;
			csb_n    <= next_csb_n;
			tx       <= next_tx;
			rx       <= next_rx;
			push     <= next_push;
			rsp_ok   <= next_rsp_ok;
			rsp_len  <= next_rsp_len;
			rsp_data <= next_rsp_data;
			sclk_s1  <= sclk_i;
			sclk_s2  <= sclk_s1;
			sclk_s3  <= sclk_s2;
			cs_s1    <= cs_b_n_i;
			cs_s2    <= cs_s1;
			mosi_s1  <= mosi_i;
			mosi_s2  <= mosi_s1;
			miso_s1  <= miso_i;
			miso_s2  <= miso_s1;
		end
	end

	// Pins: the master drives clock, data out and selects; the slave drives only its data out.
	assign role_master = (role == ROLE_MASTER);
	assign role_slave  = (role == ROLE_SLAVE);
	assign sclk_o      = sclk_lvl;
	assign sclk_oe     = role_master;
	assign mosi_o      = tx[63];
	assign mosi_oe     = role_master;
	assign miso_o      = tx[63];
	assign miso_oe     = role_slave & ~cs_s2;
	assign cs_a_n_o    = csa_n;
	assign cs_a_oe     = role_master;
	assign cs_b_n_o    = csb_n;
	assign cs_b_oe     = role_master;

	// Responses wait in a two-entry buffer until the host takes them.
	assign rs.valid = push;
	assign rs.word  = {rsp_ok, rsp_len, rsp_data};

	csp_buffer #(.W(RESP_W), .DEPTH(RESP_DEPTH)) u_resp (
		.mclk      (mclk),
		.rst       (rst),
		.in_s      (rs),
		.out_valid (resp_valid),
		.out_ready (resp_ready),
		.out_word  ({resp_ok, resp_len, resp_data})
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_take(csp_op_t op, logic cond);
		accept && cmd_op == op && cond;
	endsequence
	sequence s_err;
		push && !rsp_ok;
	endsequence

	a_mode_decode: assert property (s_take(OP_M_EN, mode_ok && rate_ok && sel_ok)
		|=> cpol == $past(cmd_mode[1]) && cpha == $past(cmd_mode[0])) else $error("mode not decoded");
	a_rate_table: assert property (s_take(OP_S_EN, mode_ok && cmd_rate == 8'h02)
		|=> half_lim == HALF2 && role_slave) else $error("rate code not mapped");
	a_csa_select: assert property ((state == ST_MRUN) && !sel_b |-> !cs_a_n_o && cs_b_n_o)
		else $error("wrong chip select driven");
	a_enable_err: assert property (s_take(OP_M_EN, !mode_ok) |=> s_err)
		else $error("bad mode not refused");
	a_disable_off: assert property (s_take(OP_M_DIS, sel_ok) |=> role == ROLE_OFF ##0 push && rsp_ok)
		else $error("disable did not turn off");
	a_role_reject: assert property (s_take(OP_XFER, !role_master) |=> s_err ##1 state == ST_IDLE)
		else $error("transfer in wrong role accepted");
	a_cs_release: assert property ((state == ST_MRUN) && m_end |=> cs_a_n_o && cs_b_n_o ##0 push)
		else $error("chip select held after transfer");
	a_slave_cs_in: assert property (role_slave |-> !cs_b_oe && !sclk_oe)
		else $error("slave drives its select");
	a_sdis_ok: assert property (s_take(OP_S_DIS, 1'b1) |=> push && rsp_ok ##1 !role_slave)
		else $error("slave disable misbehaves");
	a_idle_clock: assert property (role_master && state == ST_IDLE |-> sclk_o == cpol)
		else $error("idle clock level wrong");

endmodule : csp_top

// >>> verification/csp_spi_peer.sv
`timescale 1ns/1ns
module csp_spi_peer (
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic cpol,
	input  wire logic cpha,
	input  wire logic as_slave,
	output logic      miso_drv,
	output logic      sclk_drv,
	output logic      mosi_drv,
	output logic      cs_n_drv
	);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic       bits[$];
	logic [7:0] sh;
	int         nb;
	time        t_last;
	time        min_gap;

	// Idle lines start high and the select stays off.
	initial begin
		{miso_drv, sclk_drv, mosi_drv, cs_n_drv} = 4'hf;
		t_last = 0;
		min_gap = 0;
	end

	// As slave, a frame start loads the reply bits and shows the first one when the phase is zero.
	always @(negedge cs_n) if (as_slave) begin
		nb = 0;
		bits.delete();
		while (tx_q.size() > 0) begin
			sh = tx_q.pop_front();
			for (int j = 7; j >= 0; j--) bits.push_back(sh[j]);
		end
		if (!cpha) miso_drv = bits.pop_front();
	end

	// Sample on the edge that the phase names, shift on the other, and time every edge.
	always @(sclk) if (as_slave && !cs_n) begin
		if (min_gap == 0 || $time - t_last < min_gap) min_gap = $time - t_last;
		t_last = $time;
		if ((sclk != cpol) ^ cpha) begin
			sh = {sh[6:0], mosi};
			nb++;
			if (nb % 8 == 0) rx_q.push_back(sh);
		end else miso_drv = (bits.size() > 0) ? bits.pop_front() : ~miso_drv;
	end

	// A released data line shows the inverse of its last value, never a stale bit.
	always @(posedge cs_n) if (as_slave) begin
		miso_drv = ~miso_drv;
	end

	// As master, frames bytes on the pin B select with a 125 ns serial clock.
	task automatic frame(input int n);
		logic [7:0] b;
		logic [7:0] r;
		sclk_drv = cpol;
		#63 cs_n_drv = 1'h0;
		for (int i = 0; i < n; i++) begin
			b = tx_q.pop_front();
			for (int j = 7; j >= 0; j--) begin
				if (!cpha) mosi_drv = b[j];
				#63 sclk_drv = ~cpol;
				if (cpha) mosi_drv = b[j];
				else r = {r[6:0], miso};
				#62 sclk_drv = cpol;
				if (cpha) r = {r[6:0], miso};
			end
			rx_q.push_back(r);
		end
		#63 cs_n_drv = 1'h1;
		mosi_drv = ~mosi_drv;
	endtask : frame
endmodule : csp_spi_peer

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb;
	import csp_pkg::*;
	logic              mclk = 1'h0;
	logic              rst = 1'h1;
	logic              cmd_valid = 1'h0;
	logic              resp_ready = 1'h0;
	csp_op_t           cmd_op = OP_S_DIS;
	logic [7:0]        cmd_mode = 8'h00;
	logic [7:0]        cmd_rate = 8'h00;
	logic [7:0]        cmd_cs_sel = 8'h00;
	logic [7:0]        cmd_len = 8'h00;
	logic [63:0]       cmd_data = 64'h0;
	logic              cmd_ready, resp_valid, resp_ok, role_master, role_slave;
	logic [3:0]        resp_len;
	logic [63:0]       resp_data;
	logic              sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic              cs_a_n_o, cs_a_oe, cs_b_n_o, cs_b_oe;
	logic              p_sclk, p_mosi, p_miso, p_cs;
	logic              pcpol = 1'h0;
	logic              pcpha = 1'h0;
	logic              peer_slave = 1'h0;
	logic              use_a = 1'h0;
	logic [RESP_W-1:0] exp_q[$];
	int                num_errors = 0;
	int                checked = 0;
	int                seed = 32'h65bc5b5f;
	int                role = 0;
	int                falls_a = 0;
	int                falls_b = 0;
	wire               sclk_w = sclk_oe ? sclk_o : p_sclk;
	wire               mosi_w = mosi_oe ? mosi_o : p_mosi;
	wire               miso_w = miso_oe ? miso_o : p_miso;
	wire               cs_b_w = cs_b_oe ? cs_b_n_o : p_cs;
	wire               sel_cs = use_a ? (cs_a_n_o | ~cs_a_oe) : cs_b_w;

	csp_top dut (
		.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_mode(cmd_mode), .cmd_rate(cmd_rate), .cmd_cs_sel(cmd_cs_sel), .cmd_len(cmd_len),
		.cmd_data(cmd_data), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_ok(resp_ok),
		.resp_len(resp_len), .resp_data(resp_data), .role_master(role_master), .role_slave(role_slave),
		.sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .cs_a_n_o(cs_a_n_o),
		.cs_a_oe(cs_a_oe), .cs_b_n_i(cs_b_w), .cs_b_n_o(cs_b_n_o), .cs_b_oe(cs_b_oe)
	);
	csp_spi_peer p (
		.sclk(sclk_w), .cs_n(sel_cs), .mosi(mosi_w), .miso(miso_w), .cpol(pcpol), .cpha(pcpha),
		.as_slave(peer_slave), .miso_drv(p_miso), .sclk_drv(p_sclk), .mosi_drv(p_mosi), .cs_n_drv(p_cs)
	);

	// Block clock and select frame counters.
	always #4 mclk = ~mclk;
	always @(negedge cs_a_n_o) falls_a++;
	always @(negedge cs_b_w) falls_b++;

	// Reference answer for a command in the current role.
	function automatic logic exp_ok(input csp_op_t op, input logic [7:0] m, r, s, l);
		logic lok;
		lok = (l >= 8'h01 && l <= 8'h08);
		case (op)
			OP_M_EN: return m <= 8'h03 && r <= 8'h04 && (s == 8'h04 || s == 8'h05);
			OP_M_DIS: return s == 8'h04 || s == 8'h05;
			OP_XFER: return role == 1 && lok && (s == 8'h04 || s == 8'h05);
			OP_S_EN: return m <= 8'h03 && r <= 8'h04;
			OP_S_READ, OP_S_WRITE: return role == 2 && lok;
			default: return 1'h1;
		endcase
	endfunction : exp_ok

	task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Presents one command until taken and queues the reference response.
	task automatic send(input csp_op_t op, input logic [7:0] m, r, s, l, input logic [63:0] d, rd);
		int   n;
		logic ok;
		logic rdop;
		@(posedge mclk);
		cmd_op <= op;
		cmd_mode <= m;
		cmd_rate <= r;
		cmd_cs_sel <= s;
		cmd_len <= l;
		cmd_data <= d;
		cmd_valid <= 1'h1;
		@(negedge mclk);
		for (n = 0; cmd_ready !== 1'h1 && n < 50000; n++) @(negedge mclk);
		chk("cmd_ready", cmd_ready, 1'h1);
		@(posedge mclk);
		cmd_valid <= 1'h0;
		ok = exp_ok(op, m, r, s, l);
		rdop = ok && (op == OP_XFER || op == OP_S_READ);
		exp_q.push_back({ok, rdop ? l[3:0] : 4'h0, rd});
		if (ok) case (op)
			OP_M_EN: role = 1;
			OP_M_DIS: role = 0;
			OP_S_EN: role = 2;
			OP_S_DIS: if (role == 2) role = 0;
			default: ;
		endcase
	endtask : send

	// Waits for a response, compares it, then pops it with one ready pulse.
	task automatic pop();
		int                n;
		logic [RESP_W-1:0] e;
		e = exp_q.pop_front();
		@(negedge mclk);
		for (n = 0; resp_valid !== 1'h1 && n < 50000; n++) @(negedge mclk);
		chk("resp_valid", resp_valid, 1'h1);
		chk("resp_ok", resp_ok, e[68]);
		chk("resp_len", resp_len, e[67:64]);
		chk("resp_data", resp_data, e[63:0]);
		@(posedge mclk);
		resp_ready <= 1'h1;
		@(posedge mclk);
		resp_ready <= 1'h0;
	endtask : pop

	task automatic run(input csp_op_t op, input logic [7:0] m, r, s, l, input logic [63:0] d);
		send(op, m, r, s, l, d, 64'h0);
		pop();
	endtask : run

	// Random command data, and random peer bytes whose right-aligned image is returned.
	task automatic fill(input logic [7:0] l, output logic [63:0] d, output logic [63:0] rd);
		logic [7:0] bb;
		d = {$random(seed), $random(seed)};
		rd = 64'h0;
		p.tx_q.delete();
		p.rx_q.delete();
		for (int k = 0; k < l; k++) begin
			bb = 8'($random(seed));
			p.tx_q.push_back(bb);
			rd = {rd[55:0], bb};
		end
	endtask : fill

	task automatic chk_rx(input logic [63:0] d, input logic [7:0] l);
		chk("wire_count", 64'(p.rx_q.size()), 64'(l));
		for (int k = 0; k < 8 && p.rx_q.size() > 0; k++) chk("wire_byte", p.rx_q.pop_front(), d[63-8*k -: 8]);
	endtask : chk_rx

	task automatic conclude();
		$display("checked=%0d num_errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude

	// Hang guard well beyond the expected run length.
	initial begin
		#800_000;
		num_errors++;
		conclude();
	end

	// Main sequence: refusals, master transfers at every rate, slave frames in every mode, buffer fill.
	initial begin
		logic [63:0] d;
		logic [63:0] rd;
		logic [7:0]  m;
		logic [7:0]  l;
		logic [7:0]  s;
		int          ea;
		int          eb;
		ea = 0;
		eb = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'h0;
		@(negedge mclk);
		chk("reset_resp", resp_valid, 1'h0);
		chk("reset_oe", {sclk_oe, mosi_oe, miso_oe, cs_a_oe, cs_b_oe}, 5'h00);
		run(OP_XFER, 8'h00, 8'h00, 8'h04, 8'h01, 64'h0);
		run(OP_S_READ, 8'h00, 8'h00, 8'h00, 8'h01, 64'h0);
		run(OP_M_EN, 8'h04, 8'h00, 8'h04, 8'h00, 64'h0);
		run(OP_M_EN, 8'h00, 8'h05, 8'h04, 8'h00, 64'h0);
		run(OP_M_EN, 8'h00, 8'h00, 8'h03, 8'h00, 64'h0);
		run(OP_M_DIS, 8'h00, 8'h00, 8'h06, 8'h00, 64'h0);
		run(OP_S_EN, 8'h04, 8'h00, 8'h00, 8'h00, 64'h0);
		run(OP_S_EN, 8'h00, 8'h05, 8'h00, 8'h00, 64'h0);
		run(OP_S_EN, 8'h00, 8'h00, 8'h00, 8'h00, 64'h0);
		run(OP_XFER, 8'h00, 8'h00, 8'h04, 8'h01, 64'h0);
		run(OP_S_WRITE, 8'h00, 8'h00, 8'h00, 8'h00, 64'h0);
		run(OP_S_READ, 8'h00, 8'h00, 8'h00, 8'h09, 64'h0);
		run(OP_S_DIS, 8'h00, 8'h00, 8'h00, 8'h00, 64'h0);
		for (int r = 0; r < 5; r++) begin
			m = 8'(r % 4);
			s = 8'(4 + r % 2);
			l = 8'(1 + {$random(seed)} % (r < 3 ? 8 : 2));
			use_a = (s == 8'h04);
			pcpol = m[1];
			pcpha = m[0];
			peer_slave = 1'h1;
			run(OP_M_EN, m, 8'(r), s, 8'h00, 64'h0);
			chk("sclk_idle", sclk_o, m[1]);
			chk("role_master", role_master, 1'h1);
			run(OP_S_READ, 8'h00, 8'h00, 8'h00, 8'h01, 64'h0);
			run(OP_XFER, m, 8'(r), s, 8'h09, 64'h0);
			run(OP_XFER, m, 8'(r), 8'h06, 8'h01, 64'h0);
			fill(l, d, rd);
			p.min_gap = 0;
			send(OP_XFER, m, 8'(r), s, l, d, rd);
			pop();
			chk("half_period", p.min_gap, 8 * (62_500_000 / (4_000_000 >> r)));
			ea += use_a;
			eb += !use_a;
			chk("frames_a", falls_a, ea);
			chk("frames_b", falls_b, eb);
			chk("cs_high", sel_cs, 1'h1);
			chk_rx(d, l);
			run(OP_M_DIS, 8'h00, 8'h00, s, 8'h00, 64'h0);
			chk("role_off", role_master, 1'h0);
		end
		peer_slave = 1'h0;
		use_a = 1'h0;
		for (int k = 0; k < 4; k++) begin
			m = 8'(k);
			l = 8'(1 + {$random(seed)} % 4);
			pcpol = m[1];
			pcpha = m[0];
			run(OP_S_EN, m, 8'(k), 8'h00, 8'h00, 64'h0);
			chk("role_slave", role_slave, 1'h1);
			fill(l, d, rd);
			run(OP_S_WRITE, 8'h00, 8'h00, 8'h00, l, d);
			send(OP_S_READ, 8'h00, 8'h00, 8'h00, l, 64'h0, rd);
			p.frame(l);
			pop();
			chk_rx(d, l);
			run(OP_S_DIS, 8'h00, 8'h00, 8'h00, 8'h00, 64'h0);
			chk("role_slave_off", role_slave, 1'h0);
		end
		// Two unread responses fill the buffer, so a third command must wait.
		send(OP_S_DIS, 8'h00, 8'h00, 8'h00, 8'h00, 64'h0, 64'h0);
		send(OP_M_DIS, 8'h00, 8'h00, 8'h04, 8'h00, 64'h0, 64'h0);
		repeat (4) @(negedge mclk);
		chk("full_refuses", cmd_ready, 1'h0);
		pop();
		pop();
		@(negedge mclk);
		chk("drained", resp_valid, 1'h0);
		conclude();
	end
endmodule : tb
